// >>> dv/interrupt_vector_wakeup_map_bench.sv
// Self-checking bench for vector selection and halt wakeup.
`default_nettype none
module interrupt_vector_wakeup_map_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst_n = 1'b0, trap_req = 1'b0, slow = 1'b0;
    logic halt_enter = 1'b0, active_halt_enter = 1'b0;
    logic [25:0] req = '0;
    logic [7:0] pa = 8'h00;
    logic irq_ack, vec_valid, vec_is_trap, halted, wake_pulse, got_trap;
    logic [23:0] vec_addr, got_addr;
    logic [4:0] vec_irq, got_irq;
    int n_got, n_fail = 0, n_checks = 0, cycles = 0;
    ivw_top u_dut (.clk(clk), .rst_n(rst_n), .top_level_ext_irq(req[0]),
        .auto_wakeup_unit(req[1]), .clock_ctrl_irq(req[2]),
        .port_a_ext_irq(pa), .port_b_ext_irq(req[4]), .port_c_ext_irq(req[5]),
        .port_d_ext_irq(req[6]), .port_e_ext_irq(req[7]),
        .spi_end_irq(req[10]), .advanced_timer_one_upd(req[11]),
        .advanced_timer_one_cc(req[12]), .general_timer_two_upd(req[13]),
        .general_timer_two_cc(req[14]), .general_timer_three_upd(req[15]),
        .general_timer_three_cc(req[16]), .i2c_irq(req[19]),
        .async_serial_port_tx(req[20]), .async_serial_port_rx(req[21]),
        .analog_converter_irq(req[22]), .basic_timer_four_upd(req[23]),
        .program_done_event(req[24]), .protected_page_write_event(req[25]),
        .trap_req(trap_req), .halt_enter(halt_enter),
        .active_halt_enter(active_halt_enter), .irq_ack(irq_ack),
        .vec_valid(vec_valid), .vec_addr(vec_addr), .vec_irq(vec_irq),
        .vec_is_trap(vec_is_trap), .halted(halted), .wake_pulse(wake_pulse));
    ivw_core_model u_core (.clk(clk), .rst_n(rst_n), .vec_valid(vec_valid),
        .vec_addr(vec_addr), .vec_irq(vec_irq), .vec_is_trap(vec_is_trap),
        .slow(slow), .irq_ack(irq_ack), .got_addr(got_addr),
        .got_irq(got_irq), .got_trap(got_trap), .n_got(n_got));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic results;
        $display("checks %0d failures %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk_v(input logic [23:0] got, input logic [23:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_b(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Code -1 is reset, -2 is the trap; the source is dropped once fetched.
    task automatic fetch(input int irq);
        int k, n0;
        n0 = n_got;
        k = 0;
        while (n_got == n0 && k < 40) begin
            @(negedge clk);
            k++;
        end
        chk_v(got_addr, irq == -1 ? 24'h008000 : irq == -2 ? 24'h008004 :
            24'h008008 + 24'(4 * irq));
        chk_b(got_trap, irq == -2);
        if (irq != -2) chk_v({19'h0, got_irq}, irq < 0 ? 24'h0 : 24'(irq));
        if (irq == -2) trap_req = 1'b0;
        if (irq == 3) pa = 8'h00;
        else if (irq >= 0) req[irq] = 1'b0;
        if (irq == 24) req[25] = 1'b0;
    endtask
    // Held sources that may not wake are released later by the I2C source.
    task automatic wk(input logic act, input int q, input logic [7:0] pins,
            input logic exp);
        int w;
        @(negedge clk);
        halt_enter = !act;
        active_halt_enter = act;
        @(negedge clk);
        halt_enter = 1'b0;
        active_halt_enter = 1'b0;
        chk_b(halted, 1'b1);
        if (q == 3) pa = pins;
        else req[q] = 1'b1;
        w = 0;
        repeat (6) begin
            @(negedge clk);
            w += int'(wake_pulse === 1'b1);
        end
        chk_b(halted, !exp);
        chk_v(24'(w), 24'(exp));
        if (!exp) req[19] = 1'b1;
        fetch(exp || q < 19 ? q : 19);
        if (!exp) fetch(q < 19 ? 19 : q);
    endtask
    task automatic t_reset;
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        fetch(-1);
        $display("test reset done");
    endtask
    task automatic t_run;
        for (int n = 0; n < 26; n++) begin
            if (n inside {8, 9, 17, 18}) continue;
            slow = n[0];
            if (n == 3) pa = 8'h02;
            else req[n] = 1'b1;
            fetch(n == 25 ? 24 : n);
        end
        trap_req = 1'b1;
        req[24] = 1'b1;
        fetch(-2);
        fetch(24);
        $display("test run vectors done");
    endtask
    task automatic t_halt;
        slow = 1'b1;
        wk(1'b0, 1, 8'h00, 1'b0);
        wk(1'b0, 3, 8'h02, 1'b0);
        wk(1'b0, 3, 8'h80, 1'b1);
        for (int n = 4; n < 8; n++) wk(1'b0, n, 8'h00, 1'b1);
        wk(1'b0, 10, 8'h00, 1'b1);
        wk(1'b0, 19, 8'h00, 1'b1);
        wk(1'b0, 0, 8'h00, 1'b0);
        wk(1'b0, 2, 8'h00, 1'b0);
        wk(1'b0, 11, 8'h00, 1'b0);
        wk(1'b0, 13, 8'h00, 1'b0);
        wk(1'b0, 21, 8'h00, 1'b0);
        wk(1'b0, 24, 8'h00, 1'b0);
        $display("test halt wake done");
    endtask
    task automatic t_active;
        wk(1'b1, 1, 8'h00, 1'b1);
        wk(1'b1, 3, 8'h02, 1'b0);
        wk(1'b1, 3, 8'h01, 1'b1);
        wk(1'b1, 5, 8'h00, 1'b1);
        wk(1'b1, 10, 8'h00, 1'b1);
        wk(1'b1, 19, 8'h00, 1'b1);
        wk(1'b1, 0, 8'h00, 1'b0);
        wk(1'b1, 2, 8'h00, 1'b0);
        wk(1'b1, 12, 8'h00, 1'b0);
        wk(1'b1, 14, 8'h00, 1'b0);
        wk(1'b1, 20, 8'h00, 1'b0);
        $display("test active halt wake done");
    endtask
    task automatic t_reset_halt;
        for (int a = 0; a < 2; a++) begin
            halt_enter = (a == 0);
            active_halt_enter = (a == 1);
            @(negedge clk);
            halt_enter = 1'b0;
            active_halt_enter = 1'b0;
            chk_b(halted, 1'b1);
            rst_n = 1'b0;
            repeat (2) @(negedge clk);
            rst_n = 1'b1;
            fetch(-1);
            chk_b(halted, 1'b0);
        end
        $display("test reset from halt done");
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            results();
        end
    end
    initial begin
        t_reset();
        t_run();
        t_halt();
        t_active();
        t_reset_halt();
        results();
    end
endmodule // interrupt_vector_wakeup_map_bench
`default_nettype wire

// >>> dv/ivw_core_model.sv
// Behavioural core that fetches and acknowledges each presented vector.
`default_nettype none
module ivw_core_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic vec_valid,
    input wire logic [23:0] vec_addr,
    input wire logic [4:0] vec_irq,
    input wire logic vec_is_trap,
    input wire logic slow,
    output logic irq_ack,
    output logic [23:0] got_addr,
    output logic [4:0] got_irq,
    output logic got_trap,
    output int n_got
);
    timeunit 1ns;
    timeprecision 1ps;
    int wait_c = 0;
    initial irq_ack = 1'b0;
    initial n_got = 0;
    // A slow core leaves the vector standing several cycles before taking it.
    always @(negedge clk) begin
        if (!rst_n || irq_ack) begin
            irq_ack <= 1'b0;
            wait_c <= 0;
        end else if (vec_valid) begin
            if (wait_c >= (slow ? 5 : 0)) irq_ack <= 1'b1;
            wait_c <= wait_c + 1;
        end
    end
    always @(posedge clk) begin
        if (rst_n && irq_ack && vec_valid) begin
            got_addr <= vec_addr;
            got_irq <= vec_irq;
            got_trap <= vec_is_trap;
            n_got <= n_got + 1;
        end
    end
endmodule // ivw_core_model
`default_nettype wire

// >>> rtl/ivw_pkg.sv
// Package of vector addresses, request numbers and wakeup maps.
`default_nettype none
package ivw_pkg;
    localparam int IVW_NUM_IRQ = 25;
    localparam logic [23:0] IVW_VEC_RESET = 24'h008000;
    localparam logic [23:0] IVW_VEC_TRAP = 24'h008004;
    localparam logic [23:0] IVW_VEC_BASE = 24'h008008;
    localparam logic [4:0] IVW_IRQ_TOP_LEVEL = 5'h00;
    localparam logic [4:0] IVW_IRQ_AUTO_WAKEUP = 5'h01;
    localparam logic [4:0] IVW_IRQ_CLOCK_CTRL = 5'h02;
    localparam logic [4:0] IVW_IRQ_PORT_A = 5'h03;
    localparam logic [4:0] IVW_IRQ_SERIAL = 5'h0a;
    localparam logic [4:0] IVW_IRQ_I2C = 5'h13;
    localparam logic [4:0] IVW_IRQ_FLASH = 5'h18;
    // Bit n set: request n may wake from plain halt.
    // Port A (bit 3) is qualified separately by pin.
    localparam logic [24:0] IVW_WAKE_HALT = 25'h00804f0;
    // Bit n set: request n may wake from active halt.
    localparam logic [24:0] IVW_WAKE_ACTIVE = 25'h00804f2;
    localparam logic [7:0] IVW_PORT_A_NOWAKE_MASK = 8'h02;
    typedef enum logic [1:0] {
        IVW_RUN = 2'b00,
        IVW_HALT = 2'b01,
        IVW_ACTIVE_HALT = 2'b10
    } ivw_mode_type;
endpackage
`default_nettype wire

// >>> rtl/ivw_sel_if.sv
// Interface between the wakeup qualifier and the vector selector.
`default_nettype none
interface ivw_sel_if;
    logic [24:0] pending;
    logic wake;
    modport qual (output pending, output wake);
    modport top (input pending, input wake);
endinterface
`default_nettype wire

// >>> rtl/ivw_top.sv
// Interrupt vector selection and low-power wakeup for the core.
// Functional notes
// - Reset vectors 0x8000, leaves both halt modes.
// - Trap vectors 0x8004, never wakes.
// - Top-level line: request 0, 0x8008, no wake.
// - Auto-wakeup: request 1, wakes active halt only.
// - Clock controller: request 2, 0x8010, no wake.
// - Ports B-E: requests 4-7, wake both modes.
// - Port A: request 3, wakes except pin one.
// - Serial end-of-transfer: request 10, wakes both.
// - Timer one: requests 11, 12, no wake.
// - Timer two: requests 13, 14, no wake.
// - I2C: request 19, 0x8054, wakes both.
// - Async serial: requests 20, 21, no wake.
// - Flash events share request 24, no wake.
`default_nettype none
module ivw_top
    import ivw_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic top_level_ext_irq,
    input wire logic auto_wakeup_unit,
    input wire logic clock_ctrl_irq,
    input wire logic [7:0] port_a_ext_irq,
    input wire logic port_b_ext_irq,
    input wire logic port_c_ext_irq,
    input wire logic port_d_ext_irq,
    input wire logic port_e_ext_irq,
    input wire logic spi_end_irq,
    input wire logic advanced_timer_one_upd,
    input wire logic advanced_timer_one_cc,
    input wire logic general_timer_two_upd,
    input wire logic general_timer_two_cc,
    input wire logic general_timer_three_upd,
    input wire logic general_timer_three_cc,
    input wire logic i2c_irq,
    input wire logic async_serial_port_tx,
    input wire logic async_serial_port_rx,
    input wire logic analog_converter_irq,
    input wire logic basic_timer_four_upd,
    input wire logic program_done_event,
    input wire logic protected_page_write_event,
    input wire logic trap_req,
    input wire logic halt_enter,
    input wire logic active_halt_enter,
    input wire logic irq_ack,
    output logic vec_valid,
    output logic [23:0] vec_addr,
    output logic [4:0] vec_irq,
    output logic vec_is_trap,
    output logic halted,
    output logic wake_pulse
);
    typedef struct packed {
        ivw_mode_type mode;
        logic boot;
        logic valid;
        logic [23:0] addr;
        logic [4:0] irq;
        logic trap;
        logic wake;
    } ivw_state_type;

    ivw_state_type st_r, st_nxt;
    logic [24:0] req;
    logic [4:0] pick;
    logic any;
    ivw_sel_if sel ();

    always_comb begin
        req = '0;
        req[0] = top_level_ext_irq;
        req[1] = auto_wakeup_unit;
        req[2] = clock_ctrl_irq;
        req[3] = |port_a_ext_irq;
        req[4] = port_b_ext_irq;
        req[5] = port_c_ext_irq;
        req[6] = port_d_ext_irq;
        req[7] = port_e_ext_irq;
        req[IVW_IRQ_SERIAL] = spi_end_irq;
        req[11] = advanced_timer_one_upd;
        req[12] = advanced_timer_one_cc;
        req[13] = general_timer_two_upd;
        req[14] = general_timer_two_cc;
        req[15] = general_timer_three_upd;
        req[16] = general_timer_three_cc;
        req[IVW_IRQ_I2C] = i2c_irq;
        req[20] = async_serial_port_tx;
        req[21] = async_serial_port_rx;
        req[22] = analog_converter_irq;
        req[23] = basic_timer_four_upd;
        req[IVW_IRQ_FLASH] = program_done_event | protected_page_write_event;
    end

    ivw_wake_qual u_qual (
        .irq_req(req),
        .port_a_pins(port_a_ext_irq),
        .mode(st_r.mode),
        .sel(sel.qual)
    );

    // Lowest request number wins, as a fixed priority.
    always_comb begin
        pick = '0;
        any = 1'b0;
        for (int i = IVW_NUM_IRQ - 1; i >= 0; i--) begin
            if (sel.pending[i]) begin
                pick = i[4:0];
                any = 1'b1;
            end
        end
    end

    always_comb begin
        st_nxt = st_r;
        st_nxt.wake = 1'b0;
        if (st_r.valid && irq_ack) begin
            st_nxt.valid = 1'b0;
        end
        if (st_r.boot) begin
            st_nxt.boot = 1'b0;
            st_nxt.valid = 1'b1;
            st_nxt.addr = IVW_VEC_RESET;
            st_nxt.irq = '0;
            st_nxt.trap = 1'b0;
        end else if (st_r.mode != IVW_RUN) begin
            if (sel.top.wake) begin
                st_nxt.mode = IVW_RUN;
                st_nxt.wake = 1'b1;
            end
        end else if (!st_r.valid) begin
            if (trap_req) begin
                st_nxt.valid = 1'b1;
                st_nxt.addr = IVW_VEC_TRAP;
                st_nxt.trap = 1'b1;
            end else if (any) begin
                st_nxt.valid = 1'b1;
                st_nxt.irq = pick;
                st_nxt.trap = 1'b0;
                st_nxt.addr = IVW_VEC_BASE + {17'h00000, pick, 2'b00};
            end else if (active_halt_enter) begin
                st_nxt.mode = IVW_ACTIVE_HALT;
            end else if (halt_enter) begin
                st_nxt.mode = IVW_HALT;
            end
        end
    end

    // Reset leaves any halt mode and restarts at the reset vector.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_r <= '{mode: IVW_RUN, boot: 1'b1, valid: 1'b0,
                      addr: 24'h000000, irq: 5'h00, trap: 1'b0,
                      wake: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign vec_valid = st_r.valid;
    assign vec_addr = st_r.addr;
    assign vec_irq = st_r.irq;
    assign vec_is_trap = st_r.trap;
    assign halted = st_r.mode != IVW_RUN;
    assign wake_pulse = st_r.wake;

    property p_boot_vec;
        @(posedge clk) disable iff (!rst_n)
        $rose(rst_n) |=> vec_valid && vec_addr == 24'h008000;
    endproperty
    a_boot_vec: assert property (p_boot_vec) else $error("no reset vector");

    property p_trap_vec;
        @(posedge clk) disable iff (!rst_n)
        vec_valid && vec_is_trap |-> vec_addr == 24'h008004;
    endproperty
    a_trap_vec: assert property (p_trap_vec) else $error("bad trap vector");

    property p_irq_vec;
        @(posedge clk) disable iff (!rst_n)
        vec_valid && !vec_is_trap && !$past(st_r.boot) && vec_irq != 0 |->
            vec_addr == 24'h008008 + {17'h00000, vec_irq, 2'b00};
    endproperty
    a_irq_vec: assert property (p_irq_vec) else $error("bad irq vector");

    property p_awu_halt;
        @(posedge clk) disable iff (!rst_n)
        st_r.mode == IVW_HALT && req == 25'h0000002 |=> halted;
    endproperty
    a_awu_halt: assert property (p_awu_halt) else $error("awu woke halt");

    property p_awu_active;
        @(posedge clk) disable iff (!rst_n)
        st_r.mode == IVW_ACTIVE_HALT && auto_wakeup_unit |=> !halted && wake_pulse;
    endproperty
    a_awu_active: assert property (p_awu_active) else $error("awu no wake");

    property p_nowake;
        @(posedge clk) disable iff (!rst_n)
        halted && (req & 25'h0080562) == 25'h0 && port_a_ext_irq == 8'h02 |=> halted;
    endproperty
    a_nowake: assert property (p_nowake) else $error("illegal wakeup");

    property p_pa1;
        @(posedge clk) disable iff (!rst_n)
        st_r.mode == IVW_HALT && req == 25'h0000008 && port_a_ext_irq == 8'h02 |=> halted;
    endproperty
    a_pa1: assert property (p_pa1) else $error("pin one woke core");

    property p_spi_wake;
        @(posedge clk) disable iff (!rst_n)
        st_r.mode == IVW_HALT && spi_end_irq |=> !halted ##1 vec_valid;
    endproperty
    a_spi_wake: assert property (p_spi_wake) else $error("spi no wake");

    property p_i2c_wake;
        @(posedge clk) disable iff (!rst_n)
        st_r.mode == IVW_ACTIVE_HALT && i2c_irq |=> wake_pulse;
    endproperty
    a_i2c_wake: assert property (p_i2c_wake) else $error("i2c no wake");

    c_trap: cover property (@(posedge clk) disable iff (!rst_n) vec_valid && vec_is_trap);
    c_wake: cover property (@(posedge clk) disable iff (!rst_n) wake_pulse);
    c_flash: cover property (@(posedge clk) disable iff (!rst_n) vec_valid && vec_irq == 5'h18);
endmodule // ivw_top
`default_nettype wire

// >>> rtl/ivw_wake_qual.sv
// Wakeup qualification of pending requests against low-power mode.
`default_nettype none
module ivw_wake_qual
    import ivw_pkg::*;
(
    input wire logic [24:0] irq_req,
    input wire logic [7:0] port_a_pins,
    input wire ivw_mode_type mode,
    ivw_sel_if.qual sel
);
    logic [24:0] wake_mask;
    logic port_a_wake;
    // Pin one of port A never wakes the core.
    assign port_a_wake = |(port_a_pins & ~IVW_PORT_A_NOWAKE_MASK);
    always_comb begin
        wake_mask = '0;
        case (mode)
            IVW_HALT: wake_mask = IVW_WAKE_HALT;
            IVW_ACTIVE_HALT: wake_mask = IVW_WAKE_ACTIVE;
            default: wake_mask = '0;
        endcase
        wake_mask[IVW_IRQ_PORT_A] = (mode != IVW_RUN) && port_a_wake;
    end
    assign sel.pending = irq_req;
    assign sel.wake = |(irq_req & wake_mask);
endmodule // ivw_wake_qual
`default_nettype wire
